// File: logic/lpsc_stop_ctrl.sv
// Stop-mode controller: clocked-sleep, deep-sleep and wake-up sequencing
`timescale 1ns/1ps
`include "lpsc_params.svh"

// Function
// [RULE1] Stop enters deep or clocked sleep by flag
// [RULE2] Clocked sleep wakes only on counter irq, reset
// [RULE3] Counter wake: no wait, service at once
// [RULE4] Reset wake: wait before reset vector
// [RULE5] Sleep entry forces priority bits to 10
// [RULE6] Pending interrupt at entry wakes immediately
// [RULE7] Clocked sleep: only oscillator and counter run
// [RULE8] Flag set: watchdog gives no reset asleep
// [RULE9] Software keeps flag set through post-wake delay
// [RULE10] Deep sleep wake restarts oscillator, then waits
// [RULE11] After wait: service interrupt or fetch vector
// [RULE12] Deep sleep stops oscillator and peripherals
// [RULE13] Watchdog option picks reset or deep sleep
// [RULE14] Push priority, set level, restore on pop
// [RULE15] Opcode 8E decodes as stop
// [RULE16] Software reconfigures wake pin before stop
// [RULE17] Static input selects short or long wait
module lpsc_stop_ctrl
  import lpsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Instruction decode
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  // Configuration
  input wire logic timer_irq_enable_flag,
  input wire logic long_wait_sel,
  input wire logic watchdog_enabled,
  input wire logic watchdog_stop_option,
  // Interrupt sources
  input wire logic irq_pending,
  input wire logic rtc_irq,
  input wire logic wake_pin,
  // Interrupt entry and return
  input wire logic irq_enter,
  input wire logic [1:0] irq_level,
  input wire logic irq_return,
  // Clock gating
  output logic osc_enable,
  output logic rtc_clk_enable,
  output logic periph_clk_enable,
  output logic cpu_clk_enable,
  // CPU and watchdog
  output logic [1:0] cc_prio,
  output logic service_irq,
  output logic fetch_reset_vec,
  output logic watchdog_hold,
  output logic watchdog_reset_req,
  output lpsc_state_t mode
);

  typedef struct packed {
    lpsc_state_t state;
    logic [`LPSC_CNT_W-1:0] cnt;
    logic cause_rst;
    logic just_in;
    logic [2:0] wsync;
    logic wake_lvl;
    logic [1:0] prio;
    logic [`LPSC_STACK_DEPTH-1:0][1:0] stk;
    logic [`LPSC_SP_W-1:0] sp;
    logic osc_en;
    logic rtc_en;
    logic per_en;
    logic cpu_en;
    logic wdg_hold;
    logic svc;
    logic fetch;
    logic wdg_rst;
  } lpsc_regs_t;

  lpsc_regs_t r_reg;
  lpsc_regs_t r_next;

  function automatic logic is_stop(input logic v, input logic [7:0] op);
    is_stop = v && (op == `LPSC_STOP_OPCODE);
  endfunction

  function automatic logic [`LPSC_CNT_W-1:0] wait_load(input logic lng);
    if (lng) begin
      wait_load = `LPSC_CNT_W'(`LPSC_WAIT_LONG - 1);
    end else begin
      wait_load = `LPSC_CNT_W'(`LPSC_WAIT_SHORT - 1);
    end
  endfunction

  logic stop_exec;
  logic cnt_done;

  assign stop_exec = is_stop(opcode_valid, opcode); // see [RULE15]
  assign cnt_done = (r_reg.cnt == '0);

  always_comb begin
    r_next = r_reg;
    r_next.svc = 1'b0;
    r_next.fetch = 1'b0;
    r_next.wdg_rst = 1'b0;
    r_next.just_in = 1'b0;
    // Pin filter: a change counts once stages two and three agree
    r_next.wsync = {r_reg.wsync[1:0], wake_pin};
    if (r_reg.wsync[2] == r_reg.wsync[1]) begin
      r_next.wake_lvl = r_reg.wsync[2];
    end
    // Priority stack; push wins if both arrive together
    if (irq_enter) begin
      if (r_reg.sp < `LPSC_SP_W'(`LPSC_STACK_DEPTH)) begin
        r_next.stk[r_reg.sp[1:0]] = r_reg.prio; // see [RULE14]
        r_next.sp = r_reg.sp + `LPSC_SP_W'(1);
      end
      r_next.prio = irq_level; // see [RULE14]
    end else if (irq_return && r_reg.sp != '0) begin
      r_next.sp = r_reg.sp - `LPSC_SP_W'(1);
      r_next.prio = r_reg.stk[r_next.sp[1:0]]; // see [RULE14]
    end
    if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - `LPSC_CNT_W'(1);
    end
    case (r_reg.state)
      LPSC_RUN: begin
        if (stop_exec) begin
          r_next.prio = `LPSC_PRIO_SLEEP; // see [RULE5]
          r_next.just_in = 1'b1;
          if (timer_irq_enable_flag) begin
            // Watchdog is held, so no reset from it here
            r_next.state = LPSC_CSLEEP; // see [RULE1] [RULE8]
            r_next.per_en = 1'b0; // see [RULE7]
            r_next.cpu_en = 1'b0;
            r_next.wdg_hold = 1'b1; // see [RULE8]
          end else if (watchdog_enabled && !watchdog_stop_option) begin
            r_next.wdg_rst = 1'b1; // see [RULE13]
            r_next.just_in = 1'b0;
          end else begin
            r_next.state = LPSC_DSLEEP; // see [RULE1] [RULE13]
            r_next.osc_en = 1'b0; // see [RULE12]
            r_next.rtc_en = 1'b0;
            r_next.per_en = 1'b0;
            r_next.cpu_en = 1'b0;
          end
        end
      end
      LPSC_CSLEEP: begin
        if (rtc_irq || (r_reg.just_in && irq_pending)) begin
          // No oscillator restart, so no wait
          r_next.state = LPSC_RTCWIN; // see [RULE2] [RULE3] [RULE6]
          r_next.svc = 1'b1; // see [RULE3]
          r_next.cnt = wait_load(long_wait_sel);
          r_next.per_en = 1'b1;
          r_next.cpu_en = 1'b1;
          r_next.wdg_hold = 1'b0;
        end
      end
      LPSC_DSLEEP: begin
        if (r_reg.wake_lvl || (r_reg.just_in && irq_pending)) begin
          r_next.state = LPSC_STAB; // see [RULE10] [RULE6]
          r_next.cause_rst = 1'b0;
          r_next.cnt = wait_load(long_wait_sel); // see [RULE17]
          r_next.osc_en = 1'b1; // see [RULE10]
        end
      end
      LPSC_STAB: begin
        if (cnt_done) begin
          r_next.state = LPSC_RUN;
          r_next.rtc_en = 1'b1;
          r_next.per_en = 1'b1;
          r_next.cpu_en = 1'b1;
          r_next.svc = !r_reg.cause_rst; // see [RULE11]
          r_next.fetch = r_reg.cause_rst; // see [RULE4] [RULE11]
        end
      end
      LPSC_RTCWIN: begin
        // Clearing the flag early drops to deep sleep for the rest
        if (cnt_done) begin
          r_next.state = LPSC_RUN;
        end else if (!timer_irq_enable_flag) begin
          r_next.state = LPSC_DROP; // see [RULE9]
          r_next.osc_en = 1'b0;
          r_next.rtc_en = 1'b0;
          r_next.per_en = 1'b0;
          r_next.cpu_en = 1'b0;
        end
      end
      LPSC_DROP: begin
        if (cnt_done) begin
          r_next.state = LPSC_RUN;
          r_next.osc_en = 1'b1;
          r_next.rtc_en = 1'b1;
          r_next.per_en = 1'b1;
          r_next.cpu_en = 1'b1;
        end
      end
      default: begin
        r_next.state = LPSC_RUN;
      end
    endcase
  end

  // Reset starts in the wait so the vector fetch follows a settled clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_reg.state <= LPSC_STAB; // see [RULE4]
      r_reg.cnt <= `LPSC_CNT_W'(`LPSC_WAIT_LONG - 1);
      r_reg.cause_rst <= 1'b1;
      r_reg.just_in <= 1'b0;
      r_reg.wsync <= 3'h0;
      r_reg.wake_lvl <= 1'b0;
      r_reg.prio <= `LPSC_PRIO_RESET;
      r_reg.stk <= '0;
      r_reg.sp <= '0;
      r_reg.osc_en <= 1'b1;
      r_reg.rtc_en <= 1'b0;
      r_reg.per_en <= 1'b0;
      r_reg.cpu_en <= 1'b0;
      r_reg.wdg_hold <= 1'b0;
      r_reg.svc <= 1'b0;
      r_reg.fetch <= 1'b0;
      r_reg.wdg_rst <= 1'b0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign osc_enable = r_reg.osc_en;
  assign rtc_clk_enable = r_reg.rtc_en;
  assign periph_clk_enable = r_reg.per_en;
  assign cpu_clk_enable = r_reg.cpu_en;
  assign cc_prio = r_reg.prio;
  assign service_irq = r_reg.svc;
  assign fetch_reset_vec = r_reg.fetch;
  assign watchdog_hold = r_reg.wdg_hold;
  assign watchdog_reset_req = r_reg.wdg_rst;
  assign mode = r_reg.state;

  sequence s_stop_in_run;
    clk_en && r_reg.state == LPSC_RUN && stop_exec;
  endsequence

  sequence s_deep_wake;
    clk_en && r_reg.state == LPSC_DSLEEP && r_reg.wake_lvl;
  endsequence

  a_sleep_select: assert property (@(posedge clk_sys) disable iff (rst)
    s_stop_in_run |=> (r_reg.state == ($past(timer_irq_enable_flag) ?
      LPSC_CSLEEP : LPSC_DSLEEP)) || watchdog_reset_req)
    else $error("wrong sleep mode after stop"); // see [RULE1]

  a_csleep_only_rtc: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && r_reg.state == LPSC_CSLEEP && !rtc_irq && !r_reg.just_in
      |=> r_reg.state == LPSC_CSLEEP)
    else $error("clocked sleep left without counter irq"); // see [RULE2]

  a_rtc_no_wait: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && r_reg.state == LPSC_CSLEEP && rtc_irq
      |=> service_irq && cpu_clk_enable && r_reg.state == LPSC_RTCWIN)
    else $error("counter wake not serviced at once"); // see [RULE3]

  a_reset_vector_wait: assert property (@(posedge clk_sys) disable iff (rst)
    fetch_reset_vec |-> $past(r_reg.state) == LPSC_STAB
      && $past(r_reg.cause_rst))
    else $error("reset vector fetched without wait"); // see [RULE4]

  a_prio_forced: assert property (@(posedge clk_sys) disable iff (rst)
    s_stop_in_run ##1 (r_reg.state != LPSC_RUN)
      |-> cc_prio == `LPSC_PRIO_SLEEP)
    else $error("priority bits not forced on sleep"); // see [RULE5]

  a_pending_wakes: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && r_reg.just_in && irq_pending
      && r_reg.state inside {LPSC_CSLEEP, LPSC_DSLEEP}
      |=> r_reg.state inside {LPSC_RTCWIN, LPSC_STAB})
    else $error("pending interrupt did not wake"); // see [RULE6]

  a_csleep_clocks: assert property (@(posedge clk_sys) disable iff (rst)
    r_reg.state == LPSC_CSLEEP |-> osc_enable && rtc_clk_enable
      && !periph_clk_enable && !cpu_clk_enable && watchdog_hold)
    else $error("clocked sleep gating wrong"); // see [RULE7] [RULE8]

  a_deep_wait_len: assert property (@(posedge clk_sys) disable iff (rst)
    s_deep_wake |=> r_reg.state == LPSC_STAB && osc_enable
      && r_reg.cnt == (long_wait_sel ? `LPSC_CNT_W'(`LPSC_WAIT_LONG - 1)
      : `LPSC_CNT_W'(`LPSC_WAIT_SHORT - 1)))
    else $error("deep wake wait length wrong"); // see [RULE10] [RULE17]

  a_wait_to_service: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && r_reg.state == LPSC_STAB && cnt_done
      |=> (service_irq != fetch_reset_vec) && r_reg.state == LPSC_RUN)
    else $error("no resume after wait"); // see [RULE11]

  a_deep_osc_off: assert property (@(posedge clk_sys) disable iff (rst)
    r_reg.state == LPSC_DSLEEP |-> !osc_enable && !periph_clk_enable
      && !rtc_clk_enable)
    else $error("oscillator running in deep sleep"); // see [RULE12]

  a_wdg_option: assert property (@(posedge clk_sys) disable iff (rst)
    s_stop_in_run and (!timer_irq_enable_flag && watchdog_enabled
      && !watchdog_stop_option) |=> watchdog_reset_req
      && r_reg.state == LPSC_RUN)
    else $error("watchdog option ignored"); // see [RULE13]

  a_prio_level: assert property (@(posedge clk_sys) disable iff (rst)
    // A stop taken in the same cycle forces the sleep level instead
    clk_en && irq_enter && !(r_reg.state == LPSC_RUN && stop_exec)
      |=> cc_prio == $past(irq_level))
    else $error("priority not set on entry"); // see [RULE14]

  a_stop_decode: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && r_reg.state == LPSC_RUN && opcode_valid
      && opcode != `LPSC_STOP_OPCODE
      |=> r_reg.state == LPSC_RUN && !watchdog_reset_req)
    else $error("non-stop opcode acted as stop"); // see [RULE15]

  a_early_clear_drop: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && r_reg.state == LPSC_RTCWIN && !cnt_done
      && !timer_irq_enable_flag |=> r_reg.state == LPSC_DROP && !osc_enable)
    else $error("early flag clear not handled"); // see [RULE9]

endmodule

// File: logic/lpsc_params.svh
// Constants of the stop-mode controller
`ifndef LPSC_PARAMS_SVH
`define LPSC_PARAMS_SVH
`define LPSC_STOP_OPCODE 8'h8E
`define LPSC_WAIT_SHORT 256
`define LPSC_WAIT_LONG 4096
`define LPSC_CNT_W 12
`define LPSC_PRIO_SLEEP 2'h2
`define LPSC_PRIO_RESET 2'h3
`define LPSC_STACK_DEPTH 4
`define LPSC_SP_W 3
`endif

// File: logic/lpsc_pkg.sv
// Types of the stop-mode controller
package lpsc_pkg;
  typedef enum logic [2:0] {
    LPSC_RUN = 3'b000,
    LPSC_CSLEEP = 3'b001,
    LPSC_DSLEEP = 3'b010,
    LPSC_STAB = 3'b011,
    LPSC_RTCWIN = 3'b100,
    LPSC_DROP = 3'b101
  } lpsc_state_t;
endpackage

// File: verification/lpsc_cpu_model.sv
// CPU-side partner: enters and leaves the waking interrupt routine
`timescale 1ns/1ps
module lpsc_cpu_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // From the controller
  input wire logic service_irq,
  // Interrupt entry and return
  output logic irq_enter,
  output logic [1:0] irq_level,
  output logic irq_return
);
  logic [2:0] step_reg;
  // Level 1 differs from the sleep level, so push and pop both show
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_reg <= 3'h0;
    end else if (service_irq) begin
      step_reg <= 3'h1;
    end else if (step_reg != 3'h0) begin
      step_reg <= step_reg + 3'h1;
    end
  end
  assign irq_enter = (step_reg == 3'h2);
  assign irq_return = (step_reg == 3'h6);
  assign irq_level = 2'h1;
endmodule

// File: verification/low_power_stop_mode_controller_bench.sv
// Self-checking bench of the stop-mode controller
`timescale 1ns/1ps
`include "lpsc_params.svh"
module low_power_stop_mode_controller_bench
  import lpsc_pkg::*;
;
  typedef struct {
    logic flag, wde, opt, lw;
    lpsc_state_t m;
    logic wdr;
  } lpsc_row_t;
  logic clk_sys, rst, opcode_valid, flag, lw, wde, wopt, pend, rtc, pin, ce;
  logic [7:0] opcode;
  logic irq_enter, irq_return, osc, rtce, per, cpu, svc, frv, hold, wdr;
  logic [1:0] irq_level, cc_prio;
  lpsc_state_t mode;
  int err_count, total_checks;
  lpsc_row_t rows [4] = '{
    '{1'h1, 1'h1, 1'h0, 1'h0, LPSC_CSLEEP, 1'h0},
    '{1'h0, 1'h0, 1'h0, 1'h0, LPSC_DSLEEP, 1'h0},
    '{1'h0, 1'h1, 1'h0, 1'h0, LPSC_RUN, 1'h1},
    '{1'h0, 1'h1, 1'h1, 1'h1, LPSC_DSLEEP, 1'h0}};

  lpsc_stop_ctrl lpsc_stop_ctrl_i (.clk_sys(clk_sys), .rst(rst),
    .clk_en(ce), .opcode_valid(opcode_valid), .opcode(opcode),
    .timer_irq_enable_flag(flag), .long_wait_sel(lw),
    .watchdog_enabled(wde), .watchdog_stop_option(wopt),
    .irq_pending(pend), .rtc_irq(rtc), .wake_pin(pin),
    .irq_enter(irq_enter), .irq_level(irq_level), .irq_return(irq_return),
    .osc_enable(osc), .rtc_clk_enable(rtce), .periph_clk_enable(per),
    .cpu_clk_enable(cpu), .cc_prio(cc_prio), .service_irq(svc),
    .fetch_reset_vec(frv), .watchdog_hold(hold),
    .watchdog_reset_req(wdr), .mode(mode));
  lpsc_cpu_model lpsc_cpu_model_i (.clk_sys(clk_sys), .rst(rst),
    .service_irq(svc), .irq_enter(irq_enter), .irq_level(irq_level),
    .irq_return(irq_return));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait on the mode, or on the service pulse when svc_wait is set
  task automatic wait_for(lpsc_state_t m, logic svc_wait, int lim);
    int k;
    k = 0;
    while ((svc_wait ? svc !== 1'h1 : mode !== m) && k < lim) begin
      step(1);
      k++;
    end
    if (k >= lim) begin
      err_count++;
      $display("unexpected timeout waiting on mode or service");
      wrap_up();
    end
  endtask

  task automatic do_stop(logic [7:0] op);
    opcode_valid = 1'h1;
    opcode = op;
    step(1);
    opcode_valid = 1'h0;
  endtask

  // Reset, then the long stabilisation before the reset vector
  task automatic boot();
    rst = 1'h1;
    step(2);
    chk("rst mode", mode, LPSC_STAB);
    chk("rst prio", cc_prio, 8'h03);
    chk("rst clocks", {osc, rtce, per, cpu}, 8'h08);
    rst = 1'h0;
    // Counter starts at 4095: RUN lands on the 4096th edge
    step(`LPSC_WAIT_LONG - 1);
    chk("stab mode", mode, LPSC_STAB);
    wait_for(LPSC_RUN, 1'h0, 2);
    chk("reset vector", frv, 8'h01);
  endtask

  initial begin
    {opcode_valid, flag, lw, wde, wopt, pend, rtc, pin} = 8'h00;
    opcode = 8'h00;
    ce = 1'h1;
    err_count = 0;
    total_checks = 0;
    boot();
    foreach (rows[i]) begin
      {flag, wde, wopt, lw} = {rows[i].flag, rows[i].wde, rows[i].opt,
        rows[i].lw};
      // Lets the partner finish its routine before the next stop
      step(8);
      do_stop(`LPSC_STOP_OPCODE);
      chk("stop mode", mode, rows[i].m);
      chk("wdg reset", wdr, rows[i].wdr);
      if (rows[i].m == LPSC_CSLEEP) begin
        chk("sleep prio", cc_prio, 8'h02);
        chk("csleep clk", {osc, rtce, per, cpu}, 8'h0c);
        chk("csleep hold", hold, 8'h01);
        pin = 1'h1;
        step(6);
        chk("pin ignored", mode, LPSC_CSLEEP);
        {pin, rtc} = 2'h1;
        step(1);
        rtc = 1'h0;
        chk("rtc service", {svc, mode}, {1'h1, LPSC_RTCWIN});
        step(3);
        chk("pushed prio", cc_prio, 8'h01);
        step(4);
        chk("popped prio", cc_prio, 8'h02);
        // Flag stays set through the window
        wait_for(LPSC_RUN, 1'h0, 300);
      end else if (rows[i].m == LPSC_DSLEEP) begin
        chk("dsleep osc", {osc, cpu}, 8'h00);
        rtc = 1'h1;
        step(4);
        rtc = 1'h0;
        chk("rtc ignored", mode, LPSC_DSLEEP);
        // Wake pin held high as a pull-up input would
        pin = 1'h1;
        step(5);
        chk("osc restart", {mode, osc}, {LPSC_STAB, 1'h1});
        // Count loaded at N-1 on the restart edge: RUN lands N edges on
        step(lw ? `LPSC_WAIT_LONG - 1 : `LPSC_WAIT_SHORT - 1);
        chk("wait length", mode, LPSC_STAB);
        wait_for(LPSC_RUN, 1'h1, 2);
        pin = 1'h0;
        chk("wake run", {mode, cpu}, {LPSC_RUN, 1'h1});
      end
    end
    {wde, lw} = 2'h0;
    step(8);
    // With the enable low a stop must leave the block in RUN
    ce = 1'h0;
    do_stop(`LPSC_STOP_OPCODE);
    chk("frozen mode", mode, LPSC_RUN);
    ce = 1'h1;
    step(1);
    do_stop(8'h9D);
    chk("other opcode", mode, LPSC_RUN);
    flag = 1'h1;
    pend = 1'h1;
    step(1);
    do_stop(`LPSC_STOP_OPCODE);
    step(1);
    pend = 1'h0;
    chk("pending wake", {svc, mode}, {1'h1, LPSC_RTCWIN});
    step(`LPSC_WAIT_SHORT - 1);
    chk("window length", mode, LPSC_RTCWIN);
    step(1);
    chk("window end", mode, LPSC_RUN);
    do_stop(`LPSC_STOP_OPCODE);
    rtc = 1'h1;
    step(1);
    rtc = 1'h0;
    step(2);
    flag = 1'h0;
    step(1);
    chk("drop mode", {mode, cpu}, {LPSC_DROP, 1'h0});
    wait_for(LPSC_RUN, 1'h0, 300);
    chk("drop no pulse", svc, 8'h00);
    flag = 1'h1;
    do_stop(`LPSC_STOP_OPCODE);
    boot();
    wrap_up();
  end
endmodule
